/* File: mode_reg_pkg.sv */
// constants and types for the graphics dram mode register block
package mode_reg_pkg;
  localparam int ADDR_W            = 12;
  localparam int BANK_W            = 2;
  localparam int COL_W             = 8;
  localparam int BL_LO             = 0;
  localparam int BL_HI             = 1;
  localparam int RD_LO_BIT         = 2;
  localparam int BURST_ORDER_BIT   = 3;
  localparam int RD_HI_LO          = 4;
  localparam int RD_HI_HI          = 6;
  localparam int TEST_BIT          = 7;
  localparam int DLL_RST_BIT       = 8;
  localparam int WR_LO             = 9;
  localparam int WR_HI             = 11;
  localparam logic [BANK_W-1:0] MAIN_BANK  = 2'h0;
  localparam logic [1:0]        BL4_CODE   = 2'h2;
  localparam logic [1:0]        BL8_CODE   = 2'h3;
  localparam logic              SEQ_CODE   = 1'h0;
  localparam logic [3:0]        RD_MIN     = 4'h4;
  localparam logic [2:0]        WR_MIN     = 3'h1;
  localparam logic [2:0]        WR_RX_ON   = 3'h3;
  localparam int DLL_LOCK_CYC      = 20000;
  localparam int PD_BLOCK_CYC      = 10;
  localparam int CAL_TIME_NS       = 20000;
  localparam int CLK_PERIOD_NS     = 50;
  localparam int CAL_CYC           = CAL_TIME_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {BURST_NONE, BURST_4, BURST_8} burst_t;
endpackage

/* File: mode_beat_if.sv */
// interface carrying burst beat requests and column answers
`timescale 1ns/100ps
interface mode_beat_if;
  import mode_reg_pkg::*;
  logic             start;
  logic [COL_W-1:0] col;
  burst_t           burst;
  logic             busy;
  logic [COL_W-1:0] beat_col;
  logic             beat_vld;
  modport seq (input start, col, burst, output busy, beat_col, beat_vld);
  modport ctl (output start, col, burst, input busy, beat_col, beat_vld);
endinterface

/* File: burst_seq.sv */
// sequential column walker wrapping within the burst block
`timescale 1ns/100ps
module burst_seq (
  input  wire logic  clk_i,
  input  wire logic  rst_b_i,
  mode_beat_if.seq   bt
);
  import mode_reg_pkg::*;
  logic [COL_W-1:0] col_r;
  logic [COL_W-1:0] col_nxt;
  logic [2:0]       left_r;
  logic             vld_r;
  wire              is8   = (bt.burst == BURST_8);
  wire [2:0]        lowm  = is8 ? 3'h7 : 3'h3;
  wire [2:0]        low_inc = (col_r[2:0] + 3'h1) & lowm;
  assign col_nxt = {col_r[COL_W-1:3], (col_r[2:0] & ~lowm) | low_inc};
  assign bt.busy     = (left_r != 3'h0);
  assign bt.beat_col = col_r;
  assign bt.beat_vld = vld_r;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      col_r  <= '0;
      left_r <= 3'h0;
      vld_r  <= 1'b0;
    end else if (bt.start && bt.burst != BURST_NONE) begin
      col_r  <= is8 ? bt.col : {bt.col[COL_W-1:2], 2'h0};
      left_r <= is8 ? 3'h7 : 3'h3;
      vld_r  <= 1'b1;
    end else if (left_r != 3'h0) begin
      col_r  <= col_nxt;
      left_r <= left_r - 3'h1;
      vld_r  <= 1'b1;
    end else begin
      vld_r  <= 1'b0;
    end
  end
endmodule

/* File: mode_reg_top.sv */
// mode register capture, decode and apb view for the graphics dram
`timescale 1ns/100ps
module mode_reg_top #(
  parameter int LOCK_CYC = mode_reg_pkg::DLL_LOCK_CYC,
  parameter int CAL_WAIT = mode_reg_pkg::CAL_CYC
) (
  input  wire logic                           CLK_SYS_I,
  input  wire logic                           RST_B_I,
  input  wire logic                           CKE_I,
  input  wire logic                           CS_B_I,
  input  wire logic                           ROW_B_I,
  input  wire logic                           COL_B_I,
  input  wire logic                           WE_B_I,
  input  wire logic [mode_reg_pkg::ADDR_W-1:0] ADDR_I,
  input  wire logic [mode_reg_pkg::BANK_W-1:0] BANK_I,
  input  wire logic                           PSEL_I,
  input  wire logic                           PENABLE_I,
  input  wire logic                           PWRITE_I,
  input  wire logic [7:0]                     PADDR_I,
  input  wire logic [31:0]                    PWDATA_I,
  output logic      [31:0]                    PRDATA_O,
  output logic                                PREADY_O,
  output logic                                PSLVERR_O,
  output logic [mode_reg_pkg::COL_W-1:0]      BEAT_COL_O,
  output logic                                BEAT_VLD_O,
  output logic                                RD_DATA_VLD_O,
  output logic                                WR_DATA_TAKE_O,
  output logic                                RX_EN_O,
  output logic                                TEST_MODE_O,
  output logic                                DLL_LOCKED_O,
  output logic                                IMP_UPDATE_O,
  output logic                                CAL_DONE_O
);
  import mode_reg_pkg::*;
  localparam logic [7:0] MODE_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] CTRL_OFS   = 8'h08;
  localparam int CW = 16;

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  logic [ADDR_W-1:0] mode_r;
  logic              sim_en_r;
  wire cmd_sel   = CKE_I && !CS_B_I;
  wire mode_cmd  = cmd_sel && !ROW_B_I && !COL_B_I && !WE_B_I;
  wire mode_wr   = mode_cmd && (BANK_I == MAIN_BANK);
  wire ext_wr    = mode_cmd && (BANK_I != MAIN_BANK);
  wire rd_cmd    = cmd_sel && ROW_B_I && !COL_B_I && WE_B_I;
  wire wr_cmd    = cmd_sel && ROW_B_I && !COL_B_I && !WE_B_I;
  wire ref_cmd   = cmd_sel && !ROW_B_I && !COL_B_I && WE_B_I;
  wire nop_cmd   = cmd_sel && ROW_B_I && COL_B_I && WE_B_I;
  wire pd_cmd    = !CKE_I;

  ////////////////////////////////////////////////////////////////////////////
  // field decode
  wire [1:0] bl_code = mode_r[BL_HI:BL_LO];
  wire [3:0] rd_dly  = {mode_r[RD_HI_HI:RD_HI_LO], mode_r[RD_LO_BIT]};
  wire [2:0] wr_dly  = mode_r[WR_HI:WR_LO];
  wire       seq_ok  = (mode_r[BURST_ORDER_BIT] == SEQ_CODE);
  wire       bl_ok   = (bl_code == BL4_CODE) || (bl_code == BL8_CODE);
  wire       rd_ok   = (rd_dly >= RD_MIN);
  wire       wr_ok   = (wr_dly >= WR_MIN);
  wire       cfg_ok  = seq_ok && bl_ok && rd_ok && wr_ok;
  burst_t    burst_sel;
  assign burst_sel = !cfg_ok ? BURST_NONE :
                     (bl_code == BL8_CODE) ? BURST_8 : BURST_4;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire apb_acc  = PSEL_I && PENABLE_I;
  wire apb_wr   = apb_acc && PWRITE_I;
  wire hit_mode = (PADDR_I == MODE_OFS);
  wire hit_stat = (PADDR_I == STATUS_OFS);
  wire hit_ctrl = (PADDR_I == CTRL_OFS);
  wire bad_addr = !(hit_mode || hit_stat || hit_ctrl);
  wire sw_load  = apb_wr && hit_ctrl && PWDATA_I[1];
  wire sw_mode  = sim_en_r && sw_load;
  wire load     = mode_wr || sw_mode;
  wire [ADDR_W-1:0] load_val = mode_wr ? ADDR_I : PWDATA_I[ADDR_W+15:16];

  ////////////////////////////////////////////////////////////////////////////
  // dll reset and lock
  logic [CW-1:0] lock_cnt_r;
  logic [3:0]    pd_cnt_r;
  logic          pd_viol_r;
  logic          ext_seen_r;
  wire dll_start = load && load_val[DLL_RST_BIT];
  wire lock_done = (lock_cnt_r == CW'(1));
  wire [ADDR_W-1:0] mode_nxt = load ? load_val :
                    (lock_done ? (mode_r & ~(ADDR_W'(1) << DLL_RST_BIT))
                               : mode_r);

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      mode_r     <= '0;
      lock_cnt_r <= '0;
      ext_seen_r <= 1'b0;
    end else begin
      mode_r     <= mode_nxt;
      ext_seen_r <= ext_seen_r || ext_wr;
      if (dll_start)
        lock_cnt_r <= CW'(LOCK_CYC);
      else if (lock_cnt_r != '0)
        lock_cnt_r <= lock_cnt_r - CW'(1);
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pd_cnt_r  <= '0;
      pd_viol_r <= 1'b0;
    end else begin
      if (dll_start)
        pd_cnt_r <= 4'(PD_BLOCK_CYC);
      else if (pd_cnt_r != '0)
        pd_cnt_r <= pd_cnt_r - 4'h1;
      if (pd_cnt_r != '0 && pd_cmd)
        pd_viol_r <= 1'b1;
      else if (apb_wr && hit_ctrl && PWDATA_I[2])
        pd_viol_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read and write latency pipes
  logic [15:0] rd_pipe_r;
  logic [7:0]  wr_pipe_r;
  wire  [15:0] rd_tap = 16'h1 << rd_dly;
  wire  [7:0]  wr_tap = 8'h1 << wr_dly;
  wire rd_go = rd_cmd && cfg_ok;
  wire wr_go = wr_cmd && cfg_ok;
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rd_pipe_r <= '0;
      wr_pipe_r <= '0;
    end else begin
      rd_pipe_r <= {rd_pipe_r[14:0], rd_go};
      wr_pipe_r <= {wr_pipe_r[6:0], wr_go};
    end
  end
  // output flop adds one, so tap at delay minus one
  wire rd_first = |((rd_pipe_r << 1) & rd_tap);
  wire wr_first = |((wr_pipe_r << 1) & wr_tap);
  wire rd_busy  = |rd_pipe_r;
  wire wr_busy  = |wr_pipe_r;
  wire rx_on    = (wr_dly <= WR_RX_ON) || wr_go || wr_busy;

  ////////////////////////////////////////////////////////////////////////////
  // burst column walker
  mode_beat_if bt ();
  assign bt.start = rd_go || wr_go;
  assign bt.col   = ADDR_I[COL_W-1:0];
  assign bt.burst = burst_sel;
  burst_seq u_seq (
    .clk_i   (CLK_SYS_I),
    .rst_b_i (RST_B_I),
    .bt      (bt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // impedance calibration
  logic [CW-1:0] cal_cnt_r;
  wire cal_done = (cal_cnt_r == CW'(CAL_WAIT));
  wire imp_upd  = ref_cmd || (nop_cmd && !rd_busy);
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I)
      cal_cnt_r <= '0;
    else if (!cal_done)
      cal_cnt_r <= cal_cnt_r + CW'(1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // output and apb registers
  wire [31:0] status_w = {24'h0, pd_viol_r, ext_seen_r, cfg_ok,
                          cal_done, bt.busy, lock_cnt_r != '0,
                          mode_r[TEST_BIT], mode_r[DLL_RST_BIT]};
  wire [31:0] rdata_w = hit_mode ? {{(32-ADDR_W){1'b0}}, mode_r} :
                        hit_stat ? status_w :
                        hit_ctrl ? {31'h0, sim_en_r} : 32'h0;

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sim_en_r       <= 1'b0;
      PRDATA_O       <= 32'h0;
      PREADY_O       <= 1'b0;
      PSLVERR_O      <= 1'b0;
      BEAT_COL_O     <= '0;
      BEAT_VLD_O     <= 1'b0;
      RD_DATA_VLD_O  <= 1'b0;
      WR_DATA_TAKE_O <= 1'b0;
      RX_EN_O        <= 1'b0;
      TEST_MODE_O    <= 1'b0;
      DLL_LOCKED_O   <= 1'b0;
      IMP_UPDATE_O   <= 1'b0;
      CAL_DONE_O     <= 1'b0;
    end else begin
      if (apb_wr && hit_ctrl)
        sim_en_r <= PWDATA_I[0];
      PREADY_O       <= PSEL_I && !PENABLE_I;
      PRDATA_O       <= rdata_w;
      PSLVERR_O      <= PSEL_I && !PENABLE_I && bad_addr;
      BEAT_COL_O     <= bt.beat_col;
      BEAT_VLD_O     <= bt.beat_vld;
      RD_DATA_VLD_O  <= rd_first;
      WR_DATA_TAKE_O <= wr_first;
      RX_EN_O        <= rx_on;
      TEST_MODE_O    <= mode_r[TEST_BIT];
      DLL_LOCKED_O   <= (lock_cnt_r == '0);
      IMP_UPDATE_O   <= imp_upd;
      CAL_DONE_O     <= cal_done;
    end
  end
endmodule

/* File: dram_ctl_model.sv */
// controller model driving the command and address pins
`timescale 1ns/100ps
module dram_ctl_model #(
  parameter int MRD_CYC = 4
) (
  input  wire logic   clk_i,
  output logic        cke_o,
  output logic [3:0]  cmd_b_o,
  output logic [11:0] addr_o,
  output logic [1:0]  bank_o
);
  initial begin
    cke_o = 1'h1;
    cmd_b_o = 4'hF;
    addr_o = 12'h000;
    bank_o = 2'h0;
  end
  // one command edge, then deselect with the address turned around
  task automatic issue(input logic [3:0] c, input logic [11:0] a,
                       input logic [1:0] b);
    @(posedge clk_i);
    cmd_b_o <= c;
    addr_o <= a;
    bank_o <= b;
    @(posedge clk_i);
    cmd_b_o <= 4'hF;
    addr_o <= ~a;
    bank_o <= ~b;
  endtask
  // mode write on idle banks, then recovery and dll gap
  task automatic mode_write(input logic [11:0] a, input logic [1:0] b);
    issue(4'h0, a, b);
    repeat (MRD_CYC) @(posedge clk_i);
    if (a[8]) repeat (10) @(posedge clk_i);
  endtask
  task automatic set_cke(input logic v);
    @(posedge clk_i);
    cke_o <= v;
  endtask
endmodule

/* File: mode_reg_asserts.sv */
// port checks for the mode register block
`timescale 1ns/100ps
module mode_reg_asserts #(
  parameter int LOCK_CYC = mode_reg_pkg::DLL_LOCK_CYC
) (
  input wire logic        CLK_SYS_I,
  input wire logic        RST_B_I,
  input wire logic        CKE_I,
  input wire logic        CS_B_I,
  input wire logic        ROW_B_I,
  input wire logic        COL_B_I,
  input wire logic        WE_B_I,
  input wire logic [11:0] ADDR_I,
  input wire logic [1:0]  BANK_I,
  input wire logic [7:0]  BEAT_COL_O,
  input wire logic        BEAT_VLD_O,
  input wire logic        RD_DATA_VLD_O,
  input wire logic        WR_DATA_TAKE_O,
  input wire logic        RX_EN_O,
  input wire logic        TEST_MODE_O,
  input wire logic        DLL_LOCKED_O,
  input wire logic        IMP_UPDATE_O
);
  import mode_reg_pkg::*;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_B_I);
  ////////////////////////////////////////////////////////////
  wire sel = CKE_I && !CS_B_I;
  wire mw = sel && !ROW_B_I && !COL_B_I && !WE_B_I && BANK_I == MAIN_BANK;
  wire cc = sel && ROW_B_I && !COL_B_I;
  wire rf = sel && !ROW_B_I && !COL_B_I && WE_B_I;
  logic [11:0] mode_r;
  logic [15:0] rd_r;
  logic [15:0] wr_r;
  logic [31:0] lock_n;
  wire [3:0] rl = {mode_r[6:4], mode_r[2]};
  wire [2:0] wl = mode_r[11:9];
  wire bl8 = mode_r[1:0] == BL8_CODE;
  wire ok = mode_r[3] == SEQ_CODE && rl >= RD_MIN && wl >= WR_MIN
            && (bl8 || mode_r[1:0] == BL4_CODE);
  wire rg = cc && WE_B_I && ok;
  wire [11:0] mode_nxt = mw ? ADDR_I : mode_r;
  wire [15:0] rd_nxt = (rd_r >> 1) | (rg ? 16'h0001 << (rl - 4'h1) : 16'h0000);
  wire [15:0] wr_nxt = (wr_r >> 1)
                       | (cc && !WE_B_I && ok ? 16'h0001 << (wl - 3'h1) : 16'h0000);
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      mode_r <= 12'h000;
      rd_r <= 16'h0000;
      wr_r <= 16'h0000;
      lock_n <= 32'h0;
    end else begin
      lock_n <= DLL_LOCKED_O ? 32'h0 : lock_n + 32'h1;
      mode_r <= mode_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
    end
  end
  ////////////////////////////////////////////////////////////
  a_rd_delay: assert property (rd_r[0] |=> RD_DATA_VLD_O)
    else $error("read data late");
  a_wr_delay: assert property (wr_r[0] |=> WR_DATA_TAKE_O)
    else $error("write take late");
  a_test_copy: assert property (mw |-> ##2 TEST_MODE_O == $past(ADDR_I[7], 2))
    else $error("test bit wrong");
  a_dll_lock: assert property (mw && ADDR_I[8] |-> ##2 !DLL_LOCKED_O)
    else $error("dll reset wrong");
  a_lock_bound: assert property (lock_n <= LOCK_CYC)
    else $error("dll lock too long");
  a_rx_on: assert property (mw && !ADDR_I[3] && ADDR_I[11:9] inside {[1:3]} |-> ##2 RX_EN_O)
    else $error("receivers off");
  a_beat_first: assert property (rg |-> ##2 BEAT_VLD_O
    && BEAT_COL_O == ($past(ADDR_I[7:0], 2) & (bl8 ? 8'hFF : 8'hFC)))
    else $error("first beat wrong");
  a_beat_wrap: assert property (BEAT_VLD_O && $past(BEAT_VLD_O) && bl8 |-> BEAT_COL_O
    == {$past(BEAT_COL_O[7:3]), $past(BEAT_COL_O[2:0]) + 3'h1})
    else $error("beat wrap wrong");
  a_imp_upd: assert property (rf |-> ##[1:2] IMP_UPDATE_O)
    else $error("no impedance update");
  c_bl8_read: cover property (rg && bl8);
  c_dll_rst: cover property (mw && ADDR_I[8]);
  c_refresh: cover property (rf);
endmodule
bind mode_reg_top mode_reg_asserts #(.LOCK_CYC(LOCK_CYC)) mode_reg_asserts_i (
  .CLK_SYS_I(CLK_SYS_I), .RST_B_I(RST_B_I), .CKE_I(CKE_I), .CS_B_I(CS_B_I),
  .ROW_B_I(ROW_B_I), .COL_B_I(COL_B_I), .WE_B_I(WE_B_I), .ADDR_I(ADDR_I),
  .BANK_I(BANK_I), .BEAT_COL_O(BEAT_COL_O), .BEAT_VLD_O(BEAT_VLD_O),
  .RD_DATA_VLD_O(RD_DATA_VLD_O), .WR_DATA_TAKE_O(WR_DATA_TAKE_O),
  .RX_EN_O(RX_EN_O), .TEST_MODE_O(TEST_MODE_O), .DLL_LOCKED_O(DLL_LOCKED_O),
  .IMP_UPDATE_O(IMP_UPDATE_O));

/* File: graphics_dram_mode_register_tb.sv */
// self-checking bench for the graphics dram mode register
`timescale 1ns/100ps
module graphics_dram_mode_register_tb;
  import mode_reg_pkg::*;
  typedef struct {logic [11:0] mode; logic [7:0] col; int rl; int wl;} row_t;
  row_t rows [3] = '{'{12'h222, 8'h24, 4, 1}, '{12'hE77, 8'h0C, 15, 7},
                     '{12'h6C7, 8'h10, 9, 3}};
  logic clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00, bc;
  logic [31:0] pwdata = 32'h0, prdata;
  logic cke, ready, err, bv, rv, wt, rx, tm, dl, iu, cd;
  logic [3:0] cmd_b;
  logic [11:0] addr;
  logic [1:0] bank;
  int miscompares = 0, total_checks = 0;
  always #25 clk = ~clk;
  dram_ctl_model dram_ctl_model_i (.clk_i(clk), .cke_o(cke), .cmd_b_o(cmd_b),
    .addr_o(addr), .bank_o(bank));
  mode_reg_top #(.LOCK_CYC(20), .CAL_WAIT(8)) mode_reg_top_i (.CLK_SYS_I(clk),
    .RST_B_I(rst_b), .CKE_I(cke), .CS_B_I(cmd_b[3]), .ROW_B_I(cmd_b[2]),
    .COL_B_I(cmd_b[1]), .WE_B_I(cmd_b[0]), .ADDR_I(addr), .BANK_I(bank),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(ready), .PSLVERR_O(err),
    .BEAT_COL_O(bc), .BEAT_VLD_O(bv), .RD_DATA_VLD_O(rv), .WR_DATA_TAKE_O(wt),
    .RX_EN_O(rx), .TEST_MODE_O(tm), .DLL_LOCKED_O(dl), .IMP_UPDATE_O(iu),
    .CAL_DONE_O(cd));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (ready !== 1'h1 && n < 20);
    r = prdata;
    e = err;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) miscompares++;
  endtask
  // count negedges to each flag; k is one more than the edge delay
  task automatic observe(output int rk, output int wk, output logic [7:0] q[$]);
    q = {};
    rk = 0;
    wk = 0;
    for (int k = 1; k <= 20; k++) begin
      @(negedge clk);
      if (bv === 1'h1) q.push_back(bc);
      if (rv === 1'h1 && rk == 0) rk = k;
      if (wt === 1'h1 && wk == 0) wk = k;
    end
  endtask
  task automatic beats(input row_t r, input logic [7:0] q[$]);
    int bl;
    bl = r.mode[0] ? 8 : 4;
    check(q.size(), bl);
    foreach (q[i])
      check(q[i], (r.col & ~(bl - 1)) | ((r.col + i) & (bl - 1)));
  endtask
  initial begin
    logic [31:0] rd;
    logic e;
    int rk, wk;
    logic [7:0] q[$];
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    dram_ctl_model_i.mode_write(12'h000, 2'h1);
    foreach (rows[i]) begin
      dram_ctl_model_i.mode_write(rows[i].mode, MAIN_BANK);
      dram_ctl_model_i.issue(4'h5, {4'h0, rows[i].col}, 2'h0);
      observe(rk, wk, q);
      check(rk, rows[i].rl + 1);
      beats(rows[i], q);
      dram_ctl_model_i.issue(4'h4, {4'h0, rows[i].col}, 2'h0);
      observe(rk, wk, q);
      check(wk, rows[i].wl + 1);
      beats(rows[i], q);
      check(rx, rows[i].wl <= 3);
      check(tm, rows[i].mode[7]);
      apb(1'h0, 8'h00, 32'h0, rd, e);
      check(rd, rows[i].mode);
      $display("row %0d done", i);
    end
    dram_ctl_model_i.mode_write(12'h322, MAIN_BANK);
    @(negedge clk);
    check(dl, 1'h0);
    repeat (20) @(negedge clk);
    check(dl, 1'h1);
    apb(1'h0, 8'h00, 32'h0, rd, e);
    check(rd, 32'h222);
    $display("dll reset done");
    dram_ctl_model_i.mode_write(12'hFFF, 2'h1);
    apb(1'h1, 8'h00, 32'hFFF, rd, e);
    dram_ctl_model_i.set_cke(1'h0);
    dram_ctl_model_i.mode_write(12'h6C7, MAIN_BANK);
    dram_ctl_model_i.set_cke(1'h1);
    apb(1'h0, 8'h00, 32'h0, rd, e);
    check(rd, 32'h222);
    apb(1'h0, 8'h10, 32'h0, rd, e);
    check(e, 1'h1);
    check(rd, 32'h0);
    $display("refusals done");
    dram_ctl_model_i.mode_write(12'h22A, MAIN_BANK);
    dram_ctl_model_i.issue(4'h5, 12'h024, 2'h0);
    observe(rk, wk, q);
    check(rk, 0);
    check(q.size(), 0);
    dram_ctl_model_i.issue(4'h1, 12'h000, 2'h0);
    e = 1'h0;
    repeat (3) begin
      @(negedge clk);
      if (iu === 1'h1) e = 1'h1;
    end
    check(e, 1'h1);
    check(cd, 1'h1);
    $display("order and refresh done");
    dram_ctl_model_i.issue(4'h0, 12'h322, MAIN_BANK);
    dram_ctl_model_i.set_cke(1'h0);
    dram_ctl_model_i.set_cke(1'h1);
    apb(1'h0, 8'h04, 32'h0, rd, e);
    check(rd, 32'hF5);
    repeat (30) @(posedge clk);
    apb(1'h1, 8'h08, 32'h4, rd, e);
    apb(1'h0, 8'h04, 32'h0, rd, e);
    check(rd, 32'h70);
    apb(1'h1, 8'h08, 32'h1, rd, e);
    apb(1'h1, 8'h08, 32'h0E770003, rd, e);
    apb(1'h0, 8'h00, 32'h0, rd, e);
    check(rd, 32'hE77);
    check(e, 1'h0);
    $display("status and soft load done");
    @(posedge clk);
    rst_b <= 1'h0;
    repeat (5) @(posedge clk);
    check({dl, tm, rx, iu, cd}, 5'h0);
    rst_b <= 1'h1;
    repeat (2) @(negedge clk);
    check(dl, 1'h1);
    check(cd, 1'h0);
    apb(1'h0, 8'h00, 32'h0, rd, e);
    check(rd, 32'h0);
    $display("mid-run reset done");
    complete_run;
  end
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    complete_run;
  end
endmodule
